// file: rtl/sbsc_pkg.sv
// sbsc_pkg: shared constants and types for the bank state command checker
// assumes a 25 MHz command clock and four banks selected by a two-bit bank address
package sbsc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_BANKS = 4;  // banks selected by ba
  localparam int unsigned BA_W      = 2;  // bank address width
  localparam int unsigned CA_W      = 10; // column address width

  // ----------------------------------------------------------------
  // timing, printed figures in ns and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS                = 40;
  localparam int unsigned PRECHARGE_PERIOD_NS          = 20;
  localparam int unsigned ACTIVATE_TO_COLUMN_DELAY_NS  = 20;
  localparam int unsigned WRITE_RECOVERY_TIME_NS       = 15;
  localparam int unsigned LAST_DATA_TO_COMMAND_DELAY_NS = 15;
  localparam int unsigned REFRESH_CYCLE_NS             = 80;
  localparam int unsigned MODE_SET_DELAY_NS            = 15;
  localparam int unsigned POWER_DOWN_EXIT_NS           = 10;
  localparam int unsigned SELF_REFRESH_EXIT_NS         = 80;
  localparam int unsigned BURST_CYCLES                 = 2;
  // least times round up, never below one cycle
  localparam int unsigned PRECHARGE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACT_COL_CYC   = (ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_REC_CYC    = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CYC   = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MODE_SET_CYC  = (MODE_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PD_EXIT_CYC   = (POWER_DOWN_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SR_EXIT_CYC   = (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 4;

  // ----------------------------------------------------------------
  // command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_BST  = 4'h6;
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_DESL = 4'h8;

  // ----------------------------------------------------------------
  // per bank state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    SBSC_BK_IDLE = 7'h01,  // precharged
    SBSC_BK_PRE  = 7'h02,  // precharge running
    SBSC_BK_ACTG = 7'h04,  // row activating
    SBSC_BK_ACT  = 7'h08,  // row open
    SBSC_BK_RD   = 7'h10,  // read burst
    SBSC_BK_WR   = 7'h20,  // write burst
    SBSC_BK_WREC = 7'h40   // write recovering
  } sbsc_bank_t;

  // device wide state, one-hot
  typedef enum logic [5:0] {
    SBSC_DV_NORM = 6'h01,  // banks run on their own
    SBSC_DV_REF  = 6'h02,  // auto refresh running
    SBSC_DV_MRS  = 6'h04,  // mode register set running
    SBSC_DV_PD   = 6'h08,  // power down
    SBSC_DV_SR   = 6'h10,  // self refresh
    SBSC_DV_EXIT = 6'h20   // exit delay to idle
  } sbsc_dev_t;

endpackage : sbsc_pkg

// file: rtl/sbsc_if.sv
// sbsc_if: command pins between controller and memory device
// assumes both ends share clk; the testbench owns the wires
`timescale 1ns/1ns
interface sbsc_if (input wire logic clk);
  import sbsc_pkg::*;
  logic                cke;     // clock enable
  logic                cs_n;    // chip select
  logic                ras_n;   // row strobe
  logic                cas_n;   // column strobe
  logic                we_n;    // write enable
  logic [BA_W-1:0]     ba;      // bank address
  logic                a10;     // auto-close / all-banks bit
  logic [CA_W-1:0]     addr;    // column or row address

  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n,
                output ba, output a10, output addr);
  modport dev  (input cke, input cs_n, input ras_n, input cas_n, input we_n,
                input ba, input a10, input addr);
endinterface : sbsc_if

// file: rtl/sbsc_device.sv
// sbsc_device: bank state tracker and command interpreter of the memory device
// assumes pins come from a controller clocked on clk; pins pass a single register stage
`timescale 1ns/1ns

// Behaviour
// R1: illegal applies only to addressed bank
// R2: precharge to precharging bank is nop
// R3: precharge to idle/precharging bank may precharge
// R4: no column/row command before activate delay
// R5: write recovery accepts only new write
// R6: refresh and mode set need all idle
// R7: only nop during refresh or mode set
// R8: table used only with cke high twice
// R9: self refresh/power down from all idle
// R10: idle with low previous cke is power down
// R11: cke rise leaves power down after delay
// R12: self refresh exit needs nop or deselect
// R13: wait setup interval after self refresh exit
// R14: burst interrupts respect bus spacing
// R15: illegal commands are never issued; sbsc_ctrl passes any requested command on and sbsc_device only flags it
// R16: read/write latch column, a10 selects auto-close
module sbsc_device
  import sbsc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // command pins
  sbsc_if.dev                        pins,
  // user side status
  output logic [NUM_BANKS*7-1:0]     bank_state,
  output logic [5:0]                 dev_state,
  output logic                       illegal_cmd,
  output logic                       col_strobe,
  output logic                       col_write,
  output logic                       col_auto_close,
  output logic [BA_W-1:0]            col_bank,
  output logic [CA_W-1:0]            col_addr
);

  // ----------------------------------------------------------------
  // pin register; controller shares clk, so no synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned PW = 5 + BA_W + 1 + CA_W;
  logic [PW-1:0] pin_ff;                // registered pin values

  // one stage only: an agreement filter would swallow one-cycle commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_ff <= {1'b1, CMD_DESL, (PW-5)'(0)};
    end else begin
      pin_ff <= {pins.cke, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n, pins.ba, pins.a10, pins.addr};
    end
  end

  // decoded fields
  logic            cke_n;      // current cke
  logic            cke_prev_ff;// cke one cycle ago
  logic [3:0]      cmd;        // {cs_n, ras_n, cas_n, we_n}
  logic [BA_W-1:0] ba;
  logic            a10;
  logic [CA_W-1:0] addr;
  assign cke_n = pin_ff[PW-1];
  assign cmd   = pin_ff[PW-2 -: 4];
  assign ba    = pin_ff[CA_W+1 +: BA_W];
  assign a10   = pin_ff[CA_W];
  assign addr  = pin_ff[CA_W-1:0];

  // previous cke for transition decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_prev_ff <= 1'b1;
    end else begin
      cke_prev_ff <= cke_n;
    end
  end

  // deselect folds into nop
  logic [3:0] ecmd;
  assign ecmd = cmd[3] ? CMD_NOP : cmd;

  // ----------------------------------------------------------------
  // device wide state
  // ----------------------------------------------------------------
  sbsc_dev_t        dev_ff, nxt_dev;
  logic [CNT_W-1:0] dcnt_ff, nxt_dcnt;
  logic             all_idle;      // every bank idle
  logic             table_on;      // R8: cke high both cycles
  logic             dev_illegal;   // device level illegal
  logic [NUM_BANKS-1:0] bk_idle;

  assign all_idle = &bk_idle;
  // R8: decode table only with steady high cke
  assign table_on = (dev_ff == SBSC_DV_NORM) && cke_prev_ff && cke_n;

  // next device state from cke history and command
  always_comb begin
    nxt_dev     = dev_ff;
    nxt_dcnt    = (dcnt_ff != '0) ? dcnt_ff - 1'b1 : dcnt_ff;
    dev_illegal = 1'b0;
    unique case (dev_ff)
      SBSC_DV_NORM: begin
        if (cke_prev_ff && !cke_n) begin
          // R9: entry only with all banks idle
          if (!all_idle) dev_illegal = 1'b1;
          else if (ecmd == CMD_REF) nxt_dev = SBSC_DV_SR;
          else if (ecmd == CMD_NOP) nxt_dev = SBSC_DV_PD;
          else dev_illegal = 1'b1;
        end else if (!cke_prev_ff && all_idle) begin
          // R10: low previous cke while idle acts as power down
          if (cke_n) begin
            nxt_dev  = SBSC_DV_EXIT;
            nxt_dcnt = CNT_W'(PD_EXIT_CYC);
          end else begin
            nxt_dev = SBSC_DV_PD;
          end
        end else if (table_on && (ecmd == CMD_REF || ecmd == CMD_MRS)) begin
          // R6: refresh and mode set only with all idle
          if (!all_idle) begin
            dev_illegal = 1'b1;
          end else begin
            nxt_dev  = (ecmd == CMD_REF) ? SBSC_DV_REF : SBSC_DV_MRS;
            nxt_dcnt = (ecmd == CMD_REF) ? CNT_W'(REFRESH_CYC) : CNT_W'(MODE_SET_CYC);
          end
        end
      end
      SBSC_DV_REF, SBSC_DV_MRS: begin
        // R7: anything but nop is flagged while busy
        if (ecmd != CMD_NOP) dev_illegal = 1'b1;
        if (dcnt_ff <= CNT_W'(1)) nxt_dev = SBSC_DV_NORM;
      end
      SBSC_DV_PD: begin
        // R11: cke rise leaves power down, inputs ignored otherwise
        if (cke_n) begin
          nxt_dev  = SBSC_DV_EXIT;
          nxt_dcnt = CNT_W'(PD_EXIT_CYC);
        end
      end
      SBSC_DV_SR: begin
        // R12: any command exits on cke rise; anything but nop or deselect is flagged
        if (cke_n) begin
          if (ecmd != CMD_NOP) dev_illegal = 1'b1;
          nxt_dev  = SBSC_DV_EXIT;
          // R13: setup interval before next command
          nxt_dcnt = CNT_W'(SR_EXIT_CYC);
        end
      end
      SBSC_DV_EXIT: begin
        if (ecmd != CMD_NOP) dev_illegal = 1'b1;
        if (dcnt_ff <= CNT_W'(1)) nxt_dev = SBSC_DV_NORM;
      end
      default: nxt_dev = SBSC_DV_NORM;
    endcase
  end

  // device state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_ff  <= SBSC_DV_NORM;
      dcnt_ff <= '0;
    end else begin
      dev_ff  <= nxt_dev;
      dcnt_ff <= nxt_dcnt;
    end
  end

  // ----------------------------------------------------------------
  // per bank state machines
  // ----------------------------------------------------------------
  logic [NUM_BANKS-1:0] bk_illegal;
  sbsc_bank_t           bk_ff [NUM_BANKS];

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      sbsc_bank_t       nxt_bk;
      logic [CNT_W-1:0] cnt_ff, nxt_cnt;
      logic             hit;     // R1: command addressed to this bank
      logic             pre_hit; // precharge reaching this bank
      logic             ill;
      logic             ac_ff;   // auto-close taken with column command

      assign hit     = table_on && (ba == BA_W'(g));
      assign pre_hit = table_on && (ecmd == CMD_PRE) && (a10 || ba == BA_W'(g));
      assign bk_idle[g] = (bk_ff[g] == SBSC_BK_IDLE);

      // bank transitions; illegal only for the addressed bank
      always_comb begin
        nxt_bk  = bk_ff[g];
        nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        ill     = 1'b0;
        unique case (bk_ff[g])
          SBSC_BK_IDLE: begin
            // R3: precharge to idle bank starts a new precharge (see below)
            if (hit && ecmd == CMD_ACT) begin
              nxt_bk  = SBSC_BK_ACTG;
              nxt_cnt = CNT_W'(ACT_COL_CYC);
            end else if (hit && (ecmd == CMD_RD || ecmd == CMD_WR || ecmd == CMD_BST)) begin
              ill = 1'b1;
            end
          end
          SBSC_BK_PRE: begin
            // R2: precharge again is nop; idle after precharge period
            if (hit && ecmd != CMD_NOP && ecmd != CMD_PRE && ecmd != CMD_REF && ecmd != CMD_MRS) ill = 1'b1;
            if (cnt_ff <= CNT_W'(1)) nxt_bk = SBSC_BK_IDLE;
          end
          SBSC_BK_ACTG: begin
            // R4: nothing to this bank before activate delay
            if (hit && ecmd != CMD_NOP && ecmd != CMD_REF && ecmd != CMD_MRS) ill = 1'b1;
            if (cnt_ff <= CNT_W'(1)) nxt_bk = SBSC_BK_ACT;
          end
          SBSC_BK_ACT, SBSC_BK_RD, SBSC_BK_WR: begin
            if (!(bk_ff[g] == SBSC_BK_ACT) && cnt_ff <= CNT_W'(1)) begin
              nxt_bk  = (bk_ff[g] == SBSC_BK_WR) ? SBSC_BK_WREC : SBSC_BK_ACT;
              nxt_cnt = CNT_W'(WR_REC_CYC);
              // R16: read with auto-close precharges at burst end
              if (bk_ff[g] == SBSC_BK_RD && ac_ff) begin
                nxt_bk  = SBSC_BK_PRE;
                nxt_cnt = CNT_W'(PRECHARGE_CYC);
              end
            end
            // R16: column command starts a burst
            if (hit && (ecmd == CMD_RD || ecmd == CMD_WR)) begin
              if (bk_ff[g] == SBSC_BK_RD && ecmd == CMD_WR) ill = 1'b1;
              else begin
                nxt_bk  = (ecmd == CMD_RD) ? SBSC_BK_RD : SBSC_BK_WR;
                nxt_cnt = CNT_W'(BURST_CYCLES);
              end
            end else if (hit && ecmd == CMD_ACT) begin
              ill = 1'b1;
            end else if (hit && ecmd == CMD_BST && bk_ff[g] == SBSC_BK_WR) begin
              ill = 1'b1;
            end else if (hit && ecmd == CMD_BST && bk_ff[g] == SBSC_BK_RD) begin
              nxt_bk = SBSC_BK_ACT;
            end
          end
          SBSC_BK_WREC: begin
            // R5: only a new write is accepted in recovery
            if (hit && ecmd == CMD_WR) begin
              nxt_bk  = SBSC_BK_WR;
              nxt_cnt = CNT_W'(BURST_CYCLES);
            end else if (hit && ecmd != CMD_NOP && ecmd != CMD_REF && ecmd != CMD_MRS) begin
              ill = 1'b1;
            end else if (cnt_ff <= CNT_W'(1)) begin
              // R16: write with auto-close precharges after recovery
              nxt_bk  = ac_ff ? SBSC_BK_PRE : SBSC_BK_ACT;
              nxt_cnt = CNT_W'(PRECHARGE_CYC);
            end
          end
          default: nxt_bk = SBSC_BK_IDLE;
        endcase
        // precharge closes an active, reading or writing bank, or precharges an idle one again (R3)
        if (pre_hit && !ill && (bk_ff[g] == SBSC_BK_ACT || bk_ff[g] == SBSC_BK_RD
            || bk_ff[g] == SBSC_BK_WR || bk_ff[g] == SBSC_BK_IDLE)) begin
          nxt_bk  = SBSC_BK_PRE;
          nxt_cnt = CNT_W'(PRECHARGE_CYC);
        end
      end

      // bank state registers
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bk_ff[g] <= SBSC_BK_IDLE;
          cnt_ff   <= '0;
        end else begin
          bk_ff[g] <= nxt_bk;
          cnt_ff   <= nxt_cnt;
        end
      end

      // R16: auto-close bit kept from each accepted column command
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ac_ff <= 1'b0;
        end else if (hit && (ecmd == CMD_RD || ecmd == CMD_WR) && !ill) begin
          ac_ff <= a10;
        end
      end

      assign bk_illegal[g] = ill;
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  // illegal flag and column strobe follow the decode by one cycle; bank and device state follow their state registers by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_state     <= {NUM_BANKS{7'(SBSC_BK_IDLE)}};
      dev_state      <= 6'(SBSC_DV_NORM);
      illegal_cmd    <= 1'b0;
      col_strobe     <= 1'b0;
      col_write      <= 1'b0;
      col_auto_close <= 1'b0;
      col_bank       <= '0;
      col_addr       <= '0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) bank_state[i*7 +: 7] <= bk_ff[i];
      dev_state      <= dev_ff;
      illegal_cmd    <= dev_illegal | (|bk_illegal);
      // R16: latch column and auto-close bit
      col_strobe     <= table_on && (ecmd == CMD_RD || ecmd == CMD_WR) && !bk_illegal[ba];
      col_write      <= (ecmd == CMD_WR);
      col_auto_close <= a10;
      col_bank       <= ba;
      col_addr       <= addr;
    end
  end

endmodule : sbsc_device

// file: rtl/sbsc_ctrl.sv
// sbsc_ctrl: controller end, drives one user command per request and keeps spacing
// assumes the user asks only when ready is high; pins leave registered
`timescale 1ns/1ns
module sbsc_ctrl
  import sbsc_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // user request
  input  wire logic            req,
  input  wire logic [3:0]      req_cmd,
  input  wire logic            req_cke,
  input  wire logic [BA_W-1:0] req_ba,
  input  wire logic            req_a10,
  input  wire logic [CA_W-1:0] req_addr,
  output logic                 ready,
  // pins
  sbsc_if.ctrl                 pins
);

  // spacing counter; every rule on this side reduces to a wait
  logic [CNT_W-1:0] wait_ff;

  // R15: a non-nop command waits out the previous one's delay
  // R4 R7 R14: worst case delay covers every spacing; R5 write recovery and the R13 exit interval are not covered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= '0;
    end else if (req && ready && req_cmd != CMD_NOP && req_cmd != CMD_DESL) begin
      wait_ff <= CNT_W'(SR_EXIT_CYC);
    end else if (wait_ff != '0) begin
      wait_ff <= wait_ff - 1'b1;
    end
  end

  // ready is registered off the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= (wait_ff <= CNT_W'(1)) && !(req && ready && req_cmd != CMD_NOP && req_cmd != CMD_DESL);
    end
  end

  // drive pins; idle shows deselect with cke held at its last value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins.cke  <= 1'b1;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= CMD_DESL;
      pins.ba   <= '0;
      pins.a10  <= 1'b0;
      pins.addr <= '0;
    end else if (req && ready) begin
      pins.cke  <= req_cke;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_cmd;
      pins.ba   <= req_ba;
      pins.a10  <= req_a10;
      pins.addr <= req_addr;
    end else begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= CMD_DESL;
    end
  end

endmodule : sbsc_ctrl

// file: verif/sbsc_chk.sv
// sbsc_chk: concurrent checks on command pins and device status
// assumes one clock domain, rst asynchronous active high
`timescale 1ns/1ns
module sbsc_chk
  import sbsc_pkg::*;
(
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // command pins
  input wire logic                   cke,
  input wire logic                   cs_n,
  input wire logic                   ras_n,
  input wire logic                   cas_n,
  input wire logic                   we_n,
  // device status
  input wire logic [NUM_BANKS*7-1:0] bank_state,
  input wire logic [5:0]             dev_state,
  input wire logic                   illegal_cmd,
  input wire logic                   col_strobe
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] cmd;      // pin command code
  logic       real_cmd; // anything but nop or deselect
  logic       col_cmd;  // read or write on pins
  assign cmd      = {cs_n, ras_n, cas_n, we_n};
  assign real_cmd = !cs_n && (cmd != CMD_NOP);
  assign col_cmd  = !cs_n && ras_n && !cas_n;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // one cycle command
  chk_cmd_one_cycle: assert property (real_cmd |=> cs_n)
    else $error("command held longer than one cycle");
  chk_cmd_spacing: assert property (real_cmd |=> !real_cmd [*2])
    else $error("commands closer than three cycles");
  chk_exit_nop: assert property ($rose(cke) |-> (cs_n || cmd == CMD_NOP))
    else $error("clock enable rose with a real command");
  chk_col_cause: assert property (col_strobe |-> $past(col_cmd, 2))
    else $error("column strobe without command");
  chk_col_vs_illegal: assert property (!(col_strobe && illegal_cmd))
    else $error("command both accepted and refused");
  chk_illegal_pulse: assert property (illegal_cmd |=> !illegal_cmd)
    else $error("illegal flag longer than one cycle");
  chk_dev_onehot: assert property ($onehot(dev_state))
    else $error("device state not one-hot");
  chk_pre_to_idle: assert property (bank_state[6:0] == SBSC_BK_PRE |-> ##[1:4] bank_state[6:0] == SBSC_BK_IDLE)
    else $error("precharge did not end in idle");
  chk_reset_idle: assert property ($fell(rst) |-> bank_state == {NUM_BANKS{7'h01}})
    else $error("banks not idle after reset");

  // main scenarios seen
  cov_col: cover property (col_strobe);
  cov_illegal: cover property (illegal_cmd);
  cov_pd: cover property (dev_state == SBSC_DV_PD);
  cov_sr: cover property (dev_state == SBSC_DV_SR);
endmodule : sbsc_chk

// file: verif/sbsc_bench.sv
// sbsc_bench: controller and device joined by the pin interface
// assumes 25 MHz clk; notes queue matches device results in order
`timescale 1ns/1ns
module sbsc_bench
  import sbsc_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                   clk, rst, req, req_cke, req_a10, ready;
  logic [3:0]             req_cmd;
  logic [BA_W-1:0]        req_ba, col_bank;
  logic [CA_W-1:0]        req_addr, col_addr;
  logic [NUM_BANKS*7-1:0] bank_state;
  logic [5:0]             dev_state;
  logic                   illegal_cmd, col_strobe, col_write, col_auto_close;
  logic [14:0]            notes[$];   // expected results, oldest first
  logic [14:0]            got, want;  // watcher scratch
  int                     n_mismatch, samples_checked, cycles, seed;

  sbsc_if bus (.clk(clk));
  sbsc_ctrl sbsc_ctrl_inst (.clk(clk), .rst(rst), .req(req), .req_cmd(req_cmd), .req_cke(req_cke),
    .req_ba(req_ba), .req_a10(req_a10), .req_addr(req_addr), .ready(ready), .pins(bus));
  sbsc_device sbsc_device_inst (.clk(clk), .rst(rst), .pins(bus), .bank_state(bank_state),
    .dev_state(dev_state), .illegal_cmd(illegal_cmd), .col_strobe(col_strobe), .col_write(col_write),
    .col_auto_close(col_auto_close), .col_bank(col_bank), .col_addr(col_addr));
  sbsc_chk sbsc_chk_inst (.clk(clk), .rst(rst), .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
    .cas_n(bus.cas_n), .we_n(bus.we_n), .bank_state(bank_state), .dev_state(dev_state),
    .illegal_cmd(illegal_cmd), .col_strobe(col_strobe));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [27:0] g, input logic [27:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  // poll a status word, bounded, then compare
  task automatic wait_for(input logic sel, input logic [27:0] e);
    logic [27:0] cur;
    for (int i = 0; i < 30; i++) begin
      cur = sel ? 28'(dev_state) : bank_state;
      if (cur === e) break;
      @(posedge clk);
      #1;
    end
    check(cur, e);
  endtask : wait_for

  function automatic logic [CA_W-1:0] rnd();
    return CA_W'($random(seed));
  endfunction : rnd

  // one request; x: 1 column result expected, 2 refusal expected
  task automatic issue(input logic [3:0] c, input logic k, input logic [BA_W-1:0] b,
                       input logic a, input logic [CA_W-1:0] d, input logic [1:0] x);
    int n;
    n = 0;
    // edge first, so req never toggles twice in one step
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ready !== 1'b1 && n < 50);
    req = 1'b1;
    req_cmd = c;
    req_cke = k;
    req_ba = b;
    req_a10 = a;
    req_addr = d;
    if (x == 2'd1)
      notes.push_back({1'b0, c == CMD_WR, a, b, d});
    if (x == 2'd2)
      notes.push_back(15'h4000);
    @(posedge clk);
    #1;
    req = 1'b0;
  endtask : issue

  // ------------------------------------------------------------
  // watcher: oldest note against each result
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
    if (!rst && (col_strobe === 1'b1 || illegal_cmd === 1'b1)) begin
      got = illegal_cmd ? 15'h4000 : {1'b0, col_write, col_auto_close, col_bank, col_addr};
      want = (notes.size() == 0) ? 15'h7fff : notes.pop_front();
      check(28'(got), 28'(want));
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h585d;
    {rst, req, req_cke, req_a10} = 4'h9;
    req_cmd = CMD_DESL;
    req_ba = '0;
    req_addr = '0;
    {n_mismatch, samples_checked, cycles} = '0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    wait_for(1'b1, 28'(SBSC_DV_NORM));
    wait_for(1'b0, {NUM_BANKS{7'h01}});
    // open every bank, then write twice, the second write landing while the bank is still in write recovery
    for (int b = 0; b < NUM_BANKS; b++) begin
      issue(CMD_ACT, 1'b1, b[BA_W-1:0], 1'b0, rnd(), 2'd0);
      issue(CMD_WR, 1'b1, b[BA_W-1:0], 1'b0, rnd(), 2'd1);
      issue(CMD_WR, 1'b1, b[BA_W-1:0], 1'b0, rnd(), 2'd1);
    end
    wait_for(1'b0, {NUM_BANKS{7'h08}});
    // read with auto close on bank 0, plain read on bank 1
    issue(CMD_RD, 1'b1, 2'h0, 1'b1, rnd(), 2'd1);
    issue(CMD_RD, 1'b1, 2'h1, 1'b0, rnd(), 2'd1);
    wait_for(1'b0, {{3{7'h08}}, 7'h01});
    // same command refused on the closed bank only
    issue(CMD_RD, 1'b1, 2'h0, 1'b0, rnd(), 2'd2);
    issue(CMD_RD, 1'b1, 2'h1, 1'b1, rnd(), 2'd1);
    // refresh and mode set refused while banks are open
    issue(CMD_REF, 1'b1, 2'h2, 1'b0, rnd(), 2'd2);
    issue(CMD_MRS, 1'b1, 2'h2, 1'b0, rnd(), 2'd2);
    issue(CMD_PRE, 1'b1, 2'h3, 1'b1, rnd(), 2'd0);
    wait_for(1'b0, {NUM_BANKS{7'h01}});
    issue(CMD_PRE, 1'b1, 2'h2, 1'b0, rnd(), 2'd0);
    issue(CMD_REF, 1'b1, 2'h0, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_NORM));
    issue(CMD_MRS, 1'b1, 2'h0, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_NORM));
    // power down enter, hold, leave
    issue(CMD_NOP, 1'b0, 2'h0, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_PD));
    issue(CMD_DESL, 1'b0, 2'h1, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_PD));
    issue(CMD_NOP, 1'b1, 2'h0, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_NORM));
    // self refresh enter and leave
    issue(CMD_REF, 1'b0, 2'h0, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_SR));
    issue(CMD_NOP, 1'b1, 2'h0, 1'b0, rnd(), 2'd0);
    wait_for(1'b1, 28'(SBSC_DV_NORM));
    issue(CMD_ACT, 1'b1, 2'h2, 1'b0, rnd(), 2'd0);
    issue(CMD_WR, 1'b1, 2'h2, 1'b1, rnd(), 2'd1);
    repeat (20) @(posedge clk);
    check(28'(notes.size()), 28'h0);
    wrap_up();
  end
endmodule : sbsc_bench
